// ==== bcf_pkg.sv ====
/*
 * Constants, identifier tables and small lookup functions for the
 * periodic battery status framer.
 * Assumes a 50 MHz system clock and a CAN controller that takes one
 * whole frame at a time.
 */

package bcf_pkg;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] PERIOD_FAST_MS = 8'h64;
  localparam logic [7:0] PERIOD_SLOW_MS = 8'hc8;

  // Protocol selection codes
  localparam logic [4:0] PROTO_NATIVE = 5'h00;
  localparam logic [4:0] PROTO_INV_FULL = 5'h01;
  localparam logic [4:0] PROTO_GRP_SLOW_A = 5'h02;
  localparam logic [4:0] PROTO_GRP_SLOW_B = 5'h03;
  localparam logic [4:0] PROTO_GRP_SLOW_C = 5'h04;
  localparam logic [4:0] PROTO_INV_ELEVEN = 5'h05;
  localparam logic [4:0] PROTO_INV_FOUR = 5'h06;
  localparam logic [4:0] PROTO_GRP_FAST = 5'h07;
  localparam logic [4:0] PROTO_GRP_SLOW_D = 5'h08;
  localparam logic [4:0] PROTO_CHG_EXT = 5'h09;
  localparam logic [4:0] PROTO_CHG_TWO = 5'h0a;
  localparam logic [4:0] PROTO_CUSTOM = 5'h0c;

  // Rate and identifier length codes
  localparam logic [7:0] RATE_NATIVE_DFLT = 8'h00;
  localparam logic [7:0] RATE_INV_DFLT = 8'h03;
  localparam logic [7:0] RATE_INV_ALT = 8'h02;
  localparam logic [7:0] RATE_CHG_EXT_DFLT = 8'h82;
  localparam logic [7:0] RATE_CHG_EXT_ALT = 8'h83;
  localparam logic [7:0] RATE_CHG_TWO_DFLT = 8'h02;
  localparam int RATE_EXT_BIT = 7;
  localparam logic [2:0] RATE_IDX_MAX = 3'h4;
  localparam logic [7:0] CFMT_RESET = 8'h00;

  // Frame layout
  localparam logic [28:0] ID_CELLS_UPPER = 29'h036;
  localparam logic [28:0] ID_LIMITS = 29'h037;
  localparam logic [28:0] ID_AUX = 29'h038;
  localparam logic [28:0] ID_HEARTBEAT = 29'h305;
  localparam logic [3:0] DLC_FULL = 4'h8;
  localparam logic [3:0] DLC_AUX = 4'h8;
  localparam logic signed [9:0] TEMP_MAX = 10'sd127;
  localparam logic signed [9:0] TEMP_MIN = -10'sd127;

  // Register offsets
  localparam logic [7:0] REG_PROTO = 8'h00;
  localparam logic [7:0] REG_RATE = 8'h04;
  localparam logic [7:0] REG_CFMT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam int ST_OVERRUN = 1;
  localparam int ST_RX_OTHER = 2;

  localparam logic [11:0] IDS_NATIVE [8] = '{12'h031, 12'h032, 12'h033,
    12'h034, 12'h035, 12'h036, 12'h037, 12'h038};
  localparam logic [11:0] IDS_INV_FULL [16] = '{12'h351, 12'h355, 12'h356,
    12'h35a, 12'h35e, 12'h35f, 12'h360, 12'h372, 12'h373, 12'h374,
    12'h375, 12'h376, 12'h377, 12'h379, 12'h380, 12'h381};
  localparam logic [11:0] IDS_GROUP [6] = '{12'h351, 12'h355, 12'h356,
    12'h359, 12'h35c, 12'h35e};
  localparam logic [11:0] IDS_ELEVEN [11] = '{12'h311, 12'h312, 12'h313,
    12'h314, 12'h315, 12'h316, 12'h317, 12'h318, 12'h319, 12'h320,
    12'h321};
  localparam logic [28:0] IDS_CHG_EXT [3] = '{29'h1806e5f4, 29'h1806e6f4,
    29'h1806e7f4};
  localparam logic [11:0] IDS_CHG_TWO [2] = '{12'h6c1, 12'h6a1};

  function automatic logic [4:0] frame_total(input logic [4:0] proto);
    case (proto)
      PROTO_INV_FULL: frame_total = 5'h10;
      PROTO_GRP_SLOW_A, PROTO_GRP_SLOW_B, PROTO_GRP_SLOW_C,
      PROTO_GRP_FAST, PROTO_GRP_SLOW_D: frame_total = 5'h06;
      PROTO_INV_ELEVEN: frame_total = 5'h0b;
      PROTO_INV_FOUR: frame_total = 5'h04;
      PROTO_CHG_EXT: frame_total = 5'h0b;
      PROTO_CHG_TWO: frame_total = 5'h02;
      default: frame_total = 5'h08;
    endcase
  endfunction

  function automatic logic [28:0] frame_id(input logic [4:0] proto,
                                           input logic [4:0] idx);
    case (proto)
      PROTO_INV_FULL: frame_id = {17'h0, IDS_INV_FULL[idx[3:0]]};
      PROTO_GRP_SLOW_A, PROTO_GRP_SLOW_B, PROTO_GRP_SLOW_C,
      PROTO_GRP_FAST, PROTO_GRP_SLOW_D, PROTO_INV_FOUR:
        frame_id = (idx < 5'h06) ? {17'h0, IDS_GROUP[idx[2:0]]} : 29'h0;
      PROTO_INV_ELEVEN:
        frame_id = (idx < 5'h0b) ? {17'h0, IDS_ELEVEN[idx[3:0]]} : 29'h0;
      PROTO_CHG_EXT:
        frame_id = (idx < 5'h03) ? IDS_CHG_EXT[idx[1:0]]
                 : {17'h0, IDS_NATIVE[3'(idx - 5'h03)]};
      PROTO_CHG_TWO: frame_id = {17'h0, IDS_CHG_TWO[idx[0]]};
      default: frame_id = {17'h0, IDS_NATIVE[idx[2:0]]};
    endcase
  endfunction

  function automatic logic [7:0] period_ms(input logic [4:0] proto);
    case (proto)
      PROTO_GRP_SLOW_A, PROTO_GRP_SLOW_B, PROTO_GRP_SLOW_C,
      PROTO_INV_FOUR, PROTO_GRP_SLOW_D: period_ms = PERIOD_SLOW_MS;
      default: period_ms = PERIOD_FAST_MS;
    endcase
  endfunction

  function automatic logic [7:0] rate_default(input logic [4:0] proto);
    case (proto)
      PROTO_NATIVE, PROTO_CUSTOM: rate_default = RATE_NATIVE_DFLT;
      PROTO_CHG_EXT: rate_default = RATE_CHG_EXT_DFLT;
      PROTO_CHG_TWO: rate_default = RATE_CHG_TWO_DFLT;
      default: rate_default = RATE_INV_DFLT;
    endcase
  endfunction

endpackage

// ==== bcf_ms_tick.sv ====
/*
 * Millisecond enable pulse divided down from the system clock.
 * Assumes one free-running clock and a synchronous low reset.
 */
`timescale 1ns/10ps

module bcf_ms_tick #(
  parameter int CYCLES = bcf_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // One-cycle enable
  output logic tick
);

  logic [31:0] count;
  wire logic wrap = (count == 32'(CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else begin
      count <= wrap ? 32'h0 : count + 32'h1;
      tick <= wrap;
    end
  end

endmodule

// ==== bcf_aux_pack.sv ====
/*
 * Combinational packing of the auxiliary status frame payload.
 * Byte 1 of the frame sits in bits 63:56. Assumes live inputs; the
 * caller snapshots the packed word.
 */
`timescale 1ns/10ps

module bcf_aux_pack (
  // Measured values
  input wire logic [15:0] amp_hours,
  input wire logic signed [9:0] unit_temp_c,
  input wire logic [15:0] balance_map,
  input wire logic contactor_opening,
  // Output states
  input wire logic out_precharge,
  input wire logic out_opto_relay,
  input wire logic isolated_output_one,
  input wire logic isolated_output_two,
  // Packed payload
  output logic [63:0] aux_data
);

  wire logic [9:0] temp_clamped =
    (unit_temp_c > bcf_pkg::TEMP_MAX) ? bcf_pkg::TEMP_MAX :
    (unit_temp_c < bcf_pkg::TEMP_MIN) ? bcf_pkg::TEMP_MIN :
    unit_temp_c;
  // Precharge appears twice, at bit positions zero and one
  wire logic [7:0] out_states = {3'h0, isolated_output_two,
    isolated_output_one, out_opto_relay, out_precharge,
    out_precharge};

  assign aux_data = {amp_hours,
                     temp_clamped[7:0],
                     out_states,
                     8'h00,
                     balance_map,
                     7'h00, contactor_opening};

endmodule

// ==== bcf_framer.sv ====
/*
 * Periodic battery status framer: snapshots measured values each
 * period that finds it idle, then hands the profile's frames one by one to a CAN
 * controller over a valid/ready port. Holds the protocol, rate and
 * custom format registers.
 * Assumes all inputs synchronous to clk_sys and a controller that
 * sends a whole frame per handshake.
 */
`timescale 1ns/10ps

module bcf_framer #(
  parameter int MS_CYCLES = bcf_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Upper cell voltages, 1 mV
  input wire logic [15:0] cell13_mv,
  input wire logic [15:0] cell14_mv,
  input wire logic [15:0] cell15_mv,
  input wire logic [15:0] cell16_mv,
  // Limits, 0.1 V and 0.1 A
  input wire logic [15:0] charge_volt_max,
  input wire logic [15:0] charge_curr_max,
  input wire logic [15:0] discharge_curr_max,
  input wire logic [15:0] discharge_volt_min,
  // Auxiliary status
  input wire logic [15:0] amp_hours,
  input wire logic signed [9:0] unit_temp_c,
  input wire logic [15:0] balance_map,
  input wire logic contactor_opening,
  input wire logic out_precharge,
  input wire logic out_opto_relay,
  input wire logic isolated_output_one,
  input wire logic isolated_output_two,
  // Frames to the CAN controller
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [28:0] tx_id,
  output logic tx_ext,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  // Frames from the CAN controller
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_ext,
  // Controller setup
  output logic [2:0] can_bit_rate,
  output logic can_ext_id
);

  typedef enum logic [1:0] {BCF_IDLE, BCF_LOAD, BCF_HOLD} bcf_state_t;

  bcf_state_t state;
  logic [4:0] proto;
  logic [7:0] rate;
  logic [7:0] cfmt;
  logic [4:0] snap_proto;
  logic [63:0] snap_cells;
  logic [63:0] snap_lim;
  logic [63:0] snap_aux;
  logic [4:0] idx;
  logic [7:0] ms_count;
  logic [15:0] frame_count;
  logic overrun;
  logic rx_other;
  logic ms_tick;
  logic [63:0] aux_live;

  ////////////////////////////////////////////////////////////////////////
  // Dividers and payload packing

  bcf_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(ms_tick)
  );

  bcf_aux_pack u_aux (
    .amp_hours(amp_hours),
    .unit_temp_c(unit_temp_c),
    .balance_map(balance_map),
    .contactor_opening(contactor_opening),
    .out_precharge(out_precharge),
    .out_opto_relay(out_opto_relay),
    .isolated_output_one(isolated_output_one),
    .isolated_output_two(isolated_output_two),
    .aux_data(aux_live)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  wire logic wr_proto = reg_wr && (reg_addr == bcf_pkg::REG_PROTO);
  wire logic wr_rate = reg_wr && (reg_addr == bcf_pkg::REG_RATE);
  wire logic wr_cfmt = reg_wr && (reg_addr == bcf_pkg::REG_CFMT);
  wire logic wr_status = reg_wr && (reg_addr == bcf_pkg::REG_STATUS);
  wire logic [7:0] wr_code = reg_wdata[7:0];

  // Only codes 0-4 and 128-132 name a rate
  wire logic code_legal = (wr_code[6:3] == 4'h0) &&
    (wr_code[2:0] <= bcf_pkg::RATE_IDX_MAX);
  wire logic code_inv_ok = (wr_code == bcf_pkg::RATE_INV_DFLT) ||
    (wr_code == bcf_pkg::RATE_INV_ALT);
  wire logic code_chg_ok = (wr_code == bcf_pkg::RATE_CHG_EXT_DFLT) ||
    (wr_code == bcf_pkg::RATE_CHG_EXT_ALT);
  wire logic rate_ok = code_legal &&
    ((proto == bcf_pkg::PROTO_INV_FULL) ? code_inv_ok :
     (proto == bcf_pkg::PROTO_CHG_EXT) ? code_chg_ok : 1'b1);

  // Custom protocol takes its rate and ID length from the format
  wire logic [7:0] rate_eff =
    (proto == bcf_pkg::PROTO_CUSTOM) ? cfmt : rate;

  wire logic [31:0] status_word = {11'h0, idx, 13'h0, rx_other,
    overrun, (state != BCF_IDLE)};
  wire logic [31:0] next_rdata =
    (reg_addr == bcf_pkg::REG_PROTO) ? {27'h0, proto} :
    (reg_addr == bcf_pkg::REG_RATE) ? {24'h0, rate} :
    (reg_addr == bcf_pkg::REG_CFMT) ? {24'h0, cfmt} :
    (reg_addr == bcf_pkg::REG_STATUS) ? status_word :
    (reg_addr == bcf_pkg::REG_COUNT) ? {16'h0, frame_count} : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // Period timing and frame selection

  wire logic [7:0] period = bcf_pkg::period_ms(proto);
  wire logic period_tick = ms_tick && (ms_count >= period - 8'h01);
  wire logic [4:0] total = bcf_pkg::frame_total(snap_proto);
  wire logic [28:0] cur_id = bcf_pkg::frame_id(snap_proto, idx);
  wire logic last_frame = (idx == total - 5'h01);
  wire logic sent = tx_valid && tx_ready;

  // Payload words other than these three carry no modelled content
  wire logic [63:0] cur_data =
    (cur_id == bcf_pkg::ID_CELLS_UPPER) ? snap_cells :
    (cur_id == bcf_pkg::ID_LIMITS) ? snap_lim :
    (cur_id == bcf_pkg::ID_AUX) ? snap_aux : 64'h0;
  wire logic [3:0] cur_dlc = (cur_id == bcf_pkg::ID_AUX) ?
    bcf_pkg::DLC_AUX : bcf_pkg::DLC_FULL;

  // Heartbeat from the inverter carries nothing the framer uses
  wire logic rx_heartbeat = rx_valid && !rx_ext &&
    (rx_id == bcf_pkg::ID_HEARTBEAT) &&
    (proto == bcf_pkg::PROTO_INV_FULL);
  wire logic rx_flag_set = rx_valid && !rx_heartbeat;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      proto <= bcf_pkg::PROTO_NATIVE;
      rate <= bcf_pkg::RATE_NATIVE_DFLT;
      cfmt <= bcf_pkg::CFMT_RESET;
    end else begin
      if (wr_proto) begin
        proto <= reg_wdata[4:0];
        rate <= bcf_pkg::rate_default(reg_wdata[4:0]);
      end else if (wr_rate && rate_ok) begin
        rate <= wr_code;
      end
      if (wr_cfmt && code_legal) begin
        cfmt <= wr_code;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      can_bit_rate <= 3'h0;
      can_ext_id <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      can_bit_rate <= rate_eff[2:0];
      can_ext_id <= rate_eff[bcf_pkg::RATE_EXT_BIT];
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
    end
  end

  // Sticky flags: a new event wins over a write-one clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      overrun <= 1'b0;
      rx_other <= 1'b0;
    end else begin
      overrun <= (period_tick && state != BCF_IDLE) ||
        (overrun && !(wr_status && reg_wdata[bcf_pkg::ST_OVERRUN]));
      rx_other <= rx_flag_set ||
        (rx_other && !(wr_status && reg_wdata[bcf_pkg::ST_RX_OTHER]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Period counter and snapshot

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ms_count <= 8'h0;
    end else if (wr_proto) begin
      ms_count <= 8'h0;
    end else if (ms_tick) begin
      ms_count <= period_tick ? 8'h0 : ms_count + 8'h01;
    end
  end

  // A period that finds the previous set unfinished is skipped
  wire logic start = period_tick && (state == BCF_IDLE);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      snap_proto <= bcf_pkg::PROTO_NATIVE;
      snap_cells <= 64'h0;
      snap_lim <= 64'h0;
      snap_aux <= 64'h0;
    end else if (start) begin
      snap_proto <= proto;
      snap_cells <= {cell13_mv, cell14_mv, cell15_mv,
                     cell16_mv};
      snap_lim <= {charge_volt_max,
                   charge_curr_max, discharge_curr_max,
                   discharge_volt_min};
      snap_aux <= aux_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= BCF_IDLE;
      idx <= 5'h0;
      frame_count <= 16'h0;
    end else begin
      unique case (state)
        BCF_IDLE: begin
          if (start) begin
            idx <= 5'h0;
            state <= BCF_LOAD;
          end
        end
        BCF_LOAD: state <= BCF_HOLD;
        BCF_HOLD: begin
          if (sent) begin
            frame_count <= frame_count + 16'h1;
            idx <= last_frame ? 5'h0 : idx + 5'h01;
            state <= last_frame ? BCF_IDLE : BCF_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_id <= 29'h0;
      tx_ext <= 1'b0;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0;
    end else if (state == BCF_LOAD) begin
      tx_valid <= 1'b1;
      tx_id <= cur_id;
      tx_ext <= rate_eff[bcf_pkg::RATE_EXT_BIT];
      tx_dlc <= cur_dlc;
      tx_data <= cur_data;
    end else if (sent) begin
      tx_valid <= 1'b0;
    end
  end

endmodule

// ==== bcf_framer_props.sv ====
/* Concurrent checks on the ports of the status framer.
   Assumes bcf_framer timing: registered outputs, one system clock. */
`timescale 1ns/10ps

module bcf_framer_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Frame port
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic tx_ext,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  // Controller setup
  input wire logic [2:0] can_bit_rate,
  input wire logic can_ext_id
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence proto_wr(logic [4:0] p);
    reg_wr && reg_addr == 8'h00 && reg_wdata == {27'h0, p} ##1 !reg_wr;
  endsequence

  ////////////////////////////////////////////////////////////////////
  a_dlc_eight:
    assert property (tx_valid |-> tx_dlc == 4'h8)
    else $error("frame length code not eight");
  a_ext_match:
    assert property (tx_valid |-> tx_ext == can_ext_id)
    else $error("frame id length differs from setup");
  a_std_width:
    assert property (tx_valid && !tx_ext |-> tx_id[28:11] == 18'h0)
    else $error("standard id wider than eleven bits");
  a_rate_range:
    assert property (can_bit_rate <= 3'h4)
    else $error("bit rate index out of range");
  a_frame_hold:
    assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_id) && $stable(tx_data))
    else $error("pending frame changed before acceptance");
  a_gap_after:
    assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no idle cycle after acceptance");
  a_quiet_start:
    assert property ($rose(rst_b) |-> !tx_valid [*8])
    else $error("frame offered right after reset");
  a_full_rate:
    assert property (proto_wr(5'h01) |=> can_bit_rate == 3'h3 && !can_ext_id)
    else $error("full inverter profile rate not default");
  a_two_rate:
    assert property (proto_wr(5'h0a) |=> can_bit_rate == 3'h2 && !can_ext_id)
    else $error("two-frame charger rate not default");
  a_ext_rate:
    assert property (proto_wr(5'h09) |=> can_bit_rate == 3'h2 && can_ext_id)
    else $error("extended charger rate not default");
  a_rdata_quiet:
    assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");

  c_ext_frame: cover property (tx_valid && tx_ready && tx_ext);
  c_stalled: cover property (tx_valid && !tx_ready ##1 tx_valid && !tx_ready);
  c_status_rd: cover property (reg_rd && reg_addr == 8'h0c);
endmodule

bind bcf_framer bcf_framer_props bcf_framer_props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_id(tx_id), .tx_ext(tx_ext), .tx_dlc(tx_dlc), .tx_data(tx_data),
  .can_bit_rate(can_bit_rate), .can_ext_id(can_ext_id));

// ==== bcf_ctrl_model.sv ====
/* Behavioural CAN controller on the far side of the framer.
   Assumes one whole frame per handshake; stall set by the bench. */
`timescale 1ns/10ps

module bcf_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Frames from the framer
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [63:0] tx_data,
  // Frames heard on the bus
  output logic rx_valid,
  output logic [28:0] rx_id,
  output logic rx_ext
);
  int stall = 0;
  int wait_cnt = 0;
  logic [28:0] ids [$];
  logic [63:0] dat [$];

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 29'h0;
    rx_ext = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Ready only after the offer, so a slow bus is mimicked
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      ids.push_back(tx_id);
      dat.push_back(tx_data);
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid && wait_cnt >= stall) begin
      tx_ready <= 1'b1;
    end else if (tx_valid) begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // Idle id lines show the inverse, never the stale value
  task automatic send_rx(input logic [28:0] id, input logic ext);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ext <= ext;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_ext <= ~ext;
  endtask
endmodule

// ==== bcf_framer_bench.sv ====
/* Self-checking bench for the status framer with a controller model.
   Assumes MS_CYCLES of 10, so 100 ms is 1000 clock cycles. */
`timescale 1ns/10ps

module bcf_framer_bench;
  localparam int MS = 10;
  typedef struct {
    logic [4:0] proto; int n; logic [28:0] first; logic [28:0] last;
    logic [7:0] rate; int ms;
  } bcf_row_t;
  bcf_row_t rows [12] = '{
    '{5'h00, 8, 29'h031, 29'h038, 8'h00, 100},
    '{5'h01, 16, 29'h351, 29'h381, 8'h03, 100},
    '{5'h02, 6, 29'h351, 29'h35e, 8'h03, 200},
    '{5'h03, 6, 29'h351, 29'h35e, 8'h03, 200},
    '{5'h04, 6, 29'h351, 29'h35e, 8'h03, 200},
    '{5'h05, 11, 29'h311, 29'h321, 8'h03, 100},
    '{5'h06, 4, 29'h351, 29'h359, 8'h03, 200},
    '{5'h07, 6, 29'h351, 29'h35e, 8'h03, 100},
    '{5'h08, 6, 29'h351, 29'h35e, 8'h03, 200},
    '{5'h09, 11, 29'h1806e5f4, 29'h038, 8'h82, 100},
    '{5'h0a, 2, 29'h6c1, 29'h6a1, 8'h02, 100},
    '{5'h0c, 8, 29'h031, 29'h038, 8'h00, 100}};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic [15:0] cell13_mv = 16'h0d05, cell14_mv = 16'h0d06;
  logic [15:0] cell15_mv = 16'h0d07, cell16_mv = 16'h0d08;
  logic [15:0] charge_volt_max = 16'h0230, charge_curr_max = 16'h03e8;
  logic [15:0] discharge_curr_max = 16'h07d0;
  logic [15:0] discharge_volt_min = 16'h01c2;
  logic [15:0] amp_hours = 16'h1234, balance_map = 16'h8001;
  logic signed [9:0] unit_temp_c = -10'sd200;
  logic contactor_opening = 1'b1, out_precharge = 1'b1;
  logic out_opto_relay = 1'b0, isolated_output_one = 1'b1;
  logic isolated_output_two = 1'b0;
  logic tx_valid, tx_ready, tx_ext, can_ext_id, rx_valid, rx_ext;
  logic [28:0] tx_id, rx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data;
  logic [2:0] can_bit_rate;
  int error_cnt = 0, comparisons = 0, cyc = 0, t0;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  bcf_framer #(.MS_CYCLES(MS)) bcf_framer_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cell13_mv(cell13_mv), .cell14_mv(cell14_mv),
    .cell15_mv(cell15_mv), .cell16_mv(cell16_mv),
    .charge_volt_max(charge_volt_max), .charge_curr_max(charge_curr_max),
    .discharge_curr_max(discharge_curr_max),
    .discharge_volt_min(discharge_volt_min), .amp_hours(amp_hours),
    .unit_temp_c(unit_temp_c), .balance_map(balance_map),
    .contactor_opening(contactor_opening), .out_precharge(out_precharge),
    .out_opto_relay(out_opto_relay),
    .isolated_output_one(isolated_output_one),
    .isolated_output_two(isolated_output_two), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_id(tx_id), .tx_ext(tx_ext), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_ext(rx_ext), .can_bit_rate(can_bit_rate), .can_ext_id(can_ext_id));

  bcf_ctrl_model bcf_ctrl_model_inst (
    .clk_sys(clk_sys), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_ext(rx_ext));

  ////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Bounded: a longest period plus slack
  task automatic wait_frames(input int n);
    for (int i = 0; i < 2500 && bcf_ctrl_model_inst.ids.size() < n; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (bcf_ctrl_model_inst.ids.size() < n) begin
      error_cnt++;
      $display("unexpected frame count: expected %0d, seen %0d", n,
               bcf_ctrl_model_inst.ids.size());
      test_done();
    end
  endtask

  task automatic flush(input int settle);
    repeat (settle) @(posedge clk_sys);
    bcf_ctrl_model_inst.ids.delete();
    bcf_ctrl_model_inst.dat.delete();
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("tx_valid", 0, tx_valid);
    check("can_bit_rate", 0, can_bit_rate);
    reg_read(8'h14, rd);
    check("unmapped read", 0, rd);
    $display("test reset done");
    // Let the old set drain first, so no frame mixes two profiles
    foreach (rows[i]) begin
      flush(100);
      reg_write(8'h00, {27'h0, rows[i].proto});
      wait_frames(1);
      t0 = cyc;
      wait_frames(rows[i].n);
      check("frames in set", rows[i].n, bcf_ctrl_model_inst.ids.size());
      check("first id", rows[i].first, bcf_ctrl_model_inst.ids[0]);
      check("last id", rows[i].last, bcf_ctrl_model_inst.ids[rows[i].n - 1]);
      reg_read(8'h04, rd);
      check("rate code", rows[i].rate, rd);
      check("can_bit_rate", rows[i].rate[2:0], can_bit_rate);
      check("can_ext_id", rows[i].rate[7], can_ext_id);
      flush(0);
      wait_frames(1);
      check("period", rows[i].ms * MS, cyc - t0);
      $display("test profile %0d done", rows[i].proto);
    end
    flush(100);
    reg_write(8'h00, 32'h1);
    reg_write(8'h04, 32'h4);
    reg_read(8'h04, rd);
    check("refused rate", 32'h3, rd);
    reg_write(8'h04, 32'h2);
    reg_read(8'h04, rd);
    check("alternative rate", 32'h2, rd);
    bcf_ctrl_model_inst.send_rx(29'h305, 1'b0);
    reg_read(8'h0c, rd);
    check("heartbeat flag", 0, rd[2]);
    bcf_ctrl_model_inst.send_rx(29'h306, 1'b0);
    reg_read(8'h0c, rd);
    check("other frame flag", 1, rd[2]);
    reg_write(8'h0c, 32'h4);
    reg_read(8'h0c, rd);
    check("cleared flag", 0, rd[2]);
    reg_write(8'h00, 32'h9);
    reg_write(8'h04, 32'h83);
    reg_write(8'h04, 32'h3);
    reg_read(8'h04, rd);
    check("charger rate", 32'h83, rd);
    check("charger ext", 1, can_ext_id);
    reg_write(8'h00, 32'hc);
    reg_write(8'h08, 32'h81);
    reg_read(8'h08, rd);
    check("custom format", 32'h81, rd);
    check("custom rate", 4'h9, {can_ext_id, can_bit_rate});
    $display("test registers done");
    reg_write(8'h00, 32'h0);
    bcf_ctrl_model_inst.stall = 3;
    flush(100);
    wait_frames(1);
    @(posedge clk_sys);
    cell13_mv <= 16'hffff;
    unit_temp_c <= 10'sd300;
    out_precharge <= 1'b0;
    out_opto_relay <= 1'b1;
    isolated_output_one <= 1'b0;
    isolated_output_two <= 1'b1;
    contactor_opening <= 1'b0;
    wait_frames(8);
    check("cells id", 29'h036, bcf_ctrl_model_inst.ids[5]);
    check("upper cells", 64'h0d05_0d06_0d07_0d08, bcf_ctrl_model_inst.dat[5]);
    check("limits", 64'h0230_03e8_07d0_01c2, bcf_ctrl_model_inst.dat[6]);
    check("aux", 64'h1234_810b_0080_0101, bcf_ctrl_model_inst.dat[7]);
    flush(0);
    wait_frames(8);
    check("new cell 13", 16'hffff, bcf_ctrl_model_inst.dat[5][63:48]);
    check("aux again", 64'h1234_7f14_0080_0100, bcf_ctrl_model_inst.dat[7]);
    $display("test payload done");
    test_done();
  end
endmodule
